// file: hdl/tsc_top.sv
// trigger sequencer with control/status register and ahb-lite slave
`timescale 1ns/10ps
module tsc_top
    import tsc_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic IDLE_MODE,
    input wire logic [NUM_IN-1:0] TRIG_IN,
    output logic [NUM_OUT-1:0] TRIG_OUT
);
    logic [1:0] rst_sync;
    logic rst_n;
    logic [1:0] idle_sync;
    logic [NUM_IN-1:0] in_sync0;
    logic [NUM_IN-1:0] in_sync1;

    // reset release and pin synchronisers
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            idle_sync <= 2'b00;
            in_sync0 <= '0;
            in_sync1 <= '0;
        end else begin
            idle_sync <= {idle_sync[0], IDLE_MODE};
            in_sync0 <= TRIG_IN;
            in_sync1 <= in_sync0;
        end
    end

    // register state
    tsc_cst_t cst;
    tsc_cst_t next_cst;
    logic [15:0] sd_lim;
    logic [15:0] next_sd_lim;
    logic [15:0] c_lim;
    logic [15:0] next_c_lim;
    logic [15:0] t_lim;
    logic [15:0] next_t_lim;
    logic [PW_W-1:0] pwd;
    logic [PW_W-1:0] next_pwd;
    logic [7:0] prog [PROG_DEPTH];
    logic [7:0] next_prog [PROG_DEPTH];
    tsc_ahb_addr_t aph;
    tsc_ahb_addr_t next_aph;
    logic [31:0] next_hrdata;

    // engine state
    tsc_state_t state;
    tsc_state_t next_state;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] next_pc;
    logic [7:0] cmd;
    logic [7:0] next_cmd;
    logic [15:0] sd_cnt;
    logic [15:0] next_sd_cnt;
    logic [15:0] c_cnt;
    logic [15:0] next_c_cnt;
    logic [15:0] t_cnt;
    logic [15:0] next_t_cnt;
    logic [WDT_W-1:0] wdt_cnt;
    logic [WDT_W-1:0] next_wdt_cnt;
    logic [1:0] stab;
    logic [1:0] next_stab;
    logic fire;
    logic eng_take_swt;
    logic eng_stop;
    logic eng_wdto;

    logic [15:0] cst_word;
    logic [7:0] raddr;
    logic [1:0] itm;
    logic in_lvl;
    logic cond_met;
    logic halted;

    assign itm = {cst.input_wait_timing_mode_hi, cst.input_wait_timing_mode_lo};
    assign halted = cst.stop_in_idle_bit & idle_sync[1];

    always_comb begin
        cst_word = '0;
        cst_word[B_EN] = cst.module_enable_bit;
        cst_word[B_SIDL] = cst.stop_in_idle_bit;
        cst_word[B_TOGL] = cst.output_toggle_mode_bit;
        cst_word[B_SWT] = cst.software_trigger_bit;
        cst_word[B_SSEN] = cst.single_step_enable_bit;
        cst_word[B_IVIS] = cst.counter_visibility_bit;
        cst_word[B_STRT] = cst.sequencer_start_bit;
        cst_word[B_WDTO] = cst.watchdog_timeout_flag;
        cst_word[B_ITM_HI] = cst.input_wait_timing_mode_hi;
        cst_word[B_ITM_LO] = cst.input_wait_timing_mode_lo;
    end

    // bus slave: zero wait states, always okay
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign raddr = HADDR[7:0];

    always_comb begin
        next_aph.valid = HSEL & HTRANS[1] & HREADY;
        next_aph.write = HWRITE;
        next_aph.addr = raddr;
        next_cst = cst;
        // consume before the bus write, so a fresh trigger written in the
        // consuming cycle is kept rather than lost
        if (eng_take_swt) begin
            next_cst.software_trigger_bit = 1'b0;
        end
        next_sd_lim = sd_lim;
        next_c_lim = c_lim;
        next_t_lim = t_lim;
        next_pwd = pwd;
        next_prog = prog;
        next_hrdata = '0;
        // read data captured in the address phase, so live counters are
        // one cycle old by the time the master samples them
        if (next_aph.valid && !HWRITE) begin
            if (word_hit(raddr, OFF_CST)) begin
                next_hrdata = {16'h0000, cst_word};
            end else if (word_hit(raddr, OFF_SDLIM)) begin
                next_hrdata = {16'h0000, cst.counter_visibility_bit ?
                               sd_cnt : sd_lim};
            end else if (word_hit(raddr, OFF_CLIM)) begin
                next_hrdata = {16'h0000, cst.counter_visibility_bit ?
                               c_cnt : c_lim};
            end else if (word_hit(raddr, OFF_TLIM)) begin
                next_hrdata = {16'h0000, cst.counter_visibility_bit ?
                               t_cnt : t_lim};
            end else if (word_hit(raddr, OFF_PWD)) begin
                next_hrdata = {28'h0000000, pwd};
            end else if ((raddr & OFF_PROG_MASK) == OFF_PROG) begin
                next_hrdata = {24'h000000, prog[raddr[5:2]]};
            end
        end
        if (aph.valid && aph.write) begin
            if (word_hit(aph.addr, OFF_CST)) begin
                next_cst.module_enable_bit = HWDATA[B_EN];
                next_cst.stop_in_idle_bit = HWDATA[B_SIDL];
                next_cst.output_toggle_mode_bit = HWDATA[B_TOGL];
                next_cst.single_step_enable_bit = HWDATA[B_SSEN];
                next_cst.counter_visibility_bit = HWDATA[B_IVIS];
                next_cst.sequencer_start_bit = HWDATA[B_STRT];
                next_cst.input_wait_timing_mode_hi = HWDATA[B_ITM_HI];
                next_cst.input_wait_timing_mode_lo = HWDATA[B_ITM_LO];
                if (HWDATA[B_SWT]) begin
                    next_cst.software_trigger_bit = 1'b1;
                end
                if (!HWDATA[B_WDTO]) begin
                    next_cst.watchdog_timeout_flag = 1'b0;
                end
            end else if (word_hit(aph.addr, OFF_SDLIM)) begin
                next_sd_lim = HWDATA[15:0];
            end else if (word_hit(aph.addr, OFF_CLIM)) begin
                next_c_lim = HWDATA[15:0];
            end else if (word_hit(aph.addr, OFF_TLIM)) begin
                next_t_lim = HWDATA[15:0];
            end else if (word_hit(aph.addr, OFF_PWD)) begin
                next_pwd = HWDATA[PW_W-1:0];
            end else if ((aph.addr & OFF_PROG_MASK) == OFF_PROG) begin
                next_prog[aph.addr[5:2]] = HWDATA[7:0];
            end
        end
        // engine events override a software write in the same cycle
        if (eng_stop) begin
            next_cst.sequencer_start_bit = 1'b0;
        end
        if (eng_wdto) begin
            next_cst.watchdog_timeout_flag = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cst <= '0;
            sd_lim <= LIM_RESET;
            c_lim <= LIM_RESET;
            t_lim <= LIM_RESET;
            pwd <= PWD_RESET;
            aph <= '0;
            HRDATA <= '0;
            for (int i = 0; i < PROG_DEPTH; i++) begin
                prog[i] <= CMD_RESET;
            end
        end else begin
            cst <= next_cst;
            sd_lim <= next_sd_lim;
            c_lim <= next_c_lim;
            t_lim <= next_t_lim;
            pwd <= next_pwd;
            aph <= next_aph;
            HRDATA <= next_hrdata;
            prog <= next_prog;
        end
    end

    // wait condition of the current command
    always_comb begin
        in_lvl = in_sync1[cmd[1:0]];
        cond_met = 1'b0;
        unique case (tsc_op_t'(cmd[7:4]))
            OP_WHI: cond_met = in_lvl && stab >= itm;
            OP_WLO: cond_met = !in_lvl && stab >= itm;
            OP_CTRL_SWT: cond_met = cst.software_trigger_bit;
            OP_WAIT_TMR: cond_met = t_cnt >= t_lim;
            default: cond_met = 1'b0;
        endcase
    end

    always_comb begin
        next_state = state;
        next_pc = pc;
        next_cmd = cmd;
        next_sd_cnt = sd_cnt;
        next_c_cnt = c_cnt;
        next_t_cnt = t_cnt;
        next_wdt_cnt = wdt_cnt;
        next_stab = stab;
        fire = 1'b0;
        eng_take_swt = 1'b0;
        eng_stop = 1'b0;
        eng_wdto = 1'b0;
        if (!cst.module_enable_bit) begin
            next_state = ST_IDLE;
            next_pc = '0;
            next_sd_cnt = '0;
            next_c_cnt = '0;
            next_t_cnt = '0;
            next_wdt_cnt = '0;
        end else if (!cst.sequencer_start_bit) begin
            next_state = ST_IDLE;
        end else if (!halted) begin
            unique case (state)
                ST_IDLE: next_state = ST_FETCH;
                ST_FETCH: begin
                    next_cmd = prog[pc];
                    next_t_cnt = '0;
                    next_wdt_cnt = '0;
                    next_stab = '0;
                    next_state = ST_EXEC;
                end
                ST_EXEC: begin
                    next_sd_cnt = '0;
                    next_state = ST_DELAY;
                    next_pc = pc + 1'b1;
                    unique case (tsc_op_t'(cmd[7:4]))
                        OP_TRIG: fire = 1'b1;
                        OP_WHI, OP_WLO, OP_CTRL_SWT, OP_WAIT_TMR: begin
                            next_state = ST_WAIT;
                            next_pc = pc;
                        end
                        OP_LOOP: begin
                            if (c_cnt != c_lim) begin
                                next_c_cnt = c_cnt + 1'b1;
                                next_pc = cmd[PC_W-1:0];
                            end else begin
                                next_c_cnt = '0;
                            end
                        end
                        default: next_state = ST_DELAY;
                    endcase
                end
                ST_WAIT: begin
                    // input must match for itm extra samples in a row
                    if ((cmd[4] ? !in_lvl : in_lvl) && stab != 2'b11) begin
                        next_stab = stab + 1'b1;
                    end else if (cmd[4] ? in_lvl : !in_lvl) begin
                        next_stab = '0;
                    end
                    next_t_cnt = t_cnt + 1'b1;
                    if (cond_met) begin
                        eng_take_swt = cmd[7:4] == OP_CTRL_SWT;
                        next_sd_cnt = '0;
                        next_pc = pc + 1'b1;
                        next_state = ST_DELAY;
                    end else if (cmd[7:4] != OP_WAIT_TMR) begin
                        next_wdt_cnt = wdt_cnt + 1'b1;
                        if (wdt_cnt == WDT_LAST) begin
                            eng_wdto = 1'b1;
                            eng_stop = 1'b1;
                            next_state = ST_IDLE;
                        end
                    end
                end
                ST_DELAY: begin
                    if (sd_cnt >= sd_lim) begin
                        next_state = ST_FETCH;
                        if (cst.single_step_enable_bit) begin
                            eng_stop = 1'b1;
                            next_state = ST_IDLE;
                        end
                    end else begin
                        next_sd_cnt = sd_cnt + 1'b1;
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            pc <= '0;
            cmd <= CMD_RESET;
            sd_cnt <= '0;
            c_cnt <= '0;
            t_cnt <= '0;
            wdt_cnt <= '0;
            stab <= '0;
        end else begin
            state <= next_state;
            pc <= next_pc;
            cmd <= next_cmd;
            sd_cnt <= next_sd_cnt;
            c_cnt <= next_c_cnt;
            t_cnt <= next_t_cnt;
            wdt_cnt <= next_wdt_cnt;
            stab <= next_stab;
        end
    end

    tsc_trig_out u_trig_out (
        .clk(REF_CLK),
        .rst_n(rst_n),
        .enable(cst.module_enable_bit),
        .toggle_mode(cst.output_toggle_mode_bit),
        .pulse_width(pwd),
        .fire(fire),
        .sel(cmd[1:0]),
        .trig(TRIG_OUT)
    );
endmodule // tsc_top

// file: hdl/tsc_pkg.sv
// package: register map, field layout, commands and types of the trigger sequencer
package tsc_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int WDT_TIME_NS = 100000;
    localparam int WDT_CYCLES = WDT_TIME_NS / CLK_PERIOD_NS;
    localparam int WDT_W = 12;
    localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_CYCLES - 1);

    localparam int NUM_OUT = 4;
    localparam int NUM_IN = 4;
    localparam int PROG_DEPTH = 16;
    localparam int PC_W = 4;
    localparam int PW_W = 4;

    localparam logic [7:0] OFF_CST = 8'h00;
    localparam logic [7:0] OFF_SDLIM = 8'h04;
    localparam logic [7:0] OFF_CLIM = 8'h08;
    localparam logic [7:0] OFF_TLIM = 8'h0C;
    localparam logic [7:0] OFF_PWD = 8'h10;
    localparam logic [7:0] OFF_PROG = 8'h40;
    localparam logic [7:0] OFF_PROG_MASK = 8'hC0;

    localparam int B_EN = 15;
    localparam int B_SIDL = 13;
    localparam int B_TOGL = 12;
    localparam int B_SWT = 10;
    localparam int B_SSEN = 9;
    localparam int B_IVIS = 8;
    localparam int B_STRT = 7;
    localparam int B_WDTO = 6;
    localparam int B_ITM_HI = 1;
    localparam int B_ITM_LO = 0;

    localparam logic [15:0] LIM_RESET = 16'h0000;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [PW_W-1:0] PWD_RESET = 4'h0;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_TRIG = 4'h1,
        OP_WHI = 4'h2,
        OP_WLO = 4'h3,
        OP_CTRL_SWT = 4'h4,
        OP_WAIT_TMR = 4'h5,
        OP_LOOP = 4'h6
    } tsc_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_EXEC = 3'b011,
        ST_WAIT = 3'b010,
        ST_DELAY = 3'b110
    } tsc_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } tsc_ahb_addr_t;

    typedef struct packed {
        logic module_enable_bit;
        logic stop_in_idle_bit;
        logic output_toggle_mode_bit;
        logic software_trigger_bit;
        logic single_step_enable_bit;
        logic counter_visibility_bit;
        logic sequencer_start_bit;
        logic watchdog_timeout_flag;
        logic input_wait_timing_mode_hi;
        logic input_wait_timing_mode_lo;
    } tsc_cst_t;

    function automatic logic word_hit(input logic [7:0] addr,
                                      input logic [7:0] off);
        return addr[7:2] == off[7:2];
    endfunction
endpackage

// file: hdl/tsc_trig_out.sv
// trigger output stage: toggle or fixed-width pulse per output
`timescale 1ns/10ps
module tsc_trig_out
    import tsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic toggle_mode,
    input wire logic [PW_W-1:0] pulse_width,
    input wire logic fire,
    input wire logic [1:0] sel,
    output logic [NUM_OUT-1:0] trig
);
    logic [PW_W-1:0] cnt [NUM_OUT];
    logic [PW_W-1:0] next_cnt [NUM_OUT];
    logic [NUM_OUT-1:0] next_trig;

    always_comb begin
        for (int i = 0; i < NUM_OUT; i++) begin
            next_cnt[i] = cnt[i];
            next_trig[i] = trig[i];
            if (!enable) begin
                next_cnt[i] = '0;
                next_trig[i] = 1'b0;
            end else if (fire && sel == 2'(i)) begin
                if (toggle_mode) begin
                    next_trig[i] = ~trig[i];
                end else begin
                    next_trig[i] = 1'b1;
                    next_cnt[i] = pulse_width;
                end
            end else if (!toggle_mode && trig[i]) begin
                // pulse lasts pulse_width + 1 cycles
                if (cnt[i] == '0) begin
                    next_trig[i] = 1'b0;
                end else begin
                    next_cnt[i] = cnt[i] - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig <= '0;
            for (int i = 0; i < NUM_OUT; i++) begin
                cnt[i] <= '0;
            end
        end else begin
            trig <= next_trig;
            cnt <= next_cnt;
        end
    end
endmodule // tsc_trig_out

// file: test/tsc_assertions.sv
// checker: bus read-back and trigger output properties of tsc_top
`timescale 1ns/10ps
module tsc_assertions
    import tsc_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic IDLE_MODE,
    input wire logic [NUM_OUT-1:0] TRIG_OUT
);
    logic ap;
    logic wr_p;
    logic rd_p;
    logic [7:0] ad_p;
    logic [15:0] cst;
    logic [15:0] sd;
    logic [15:0] exp_sd;
    logic [3:0] pwd;
    logic [4:0] hi_cnt;
    assign ap = HSEL & HTRANS[1] & HREADY;
    // shadows hold software writes only; the hw-cleared start bit is relied on only when written 0
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_p <= 1'b0;
            rd_p <= 1'b0;
            ad_p <= 8'h00;
            cst <= 16'h0000;
            sd <= 16'h0000;
            exp_sd <= 16'h0000;
            pwd <= 4'h0;
            hi_cnt <= 5'h00;
        end else begin
            wr_p <= ap & HWRITE;
            rd_p <= ap & ~HWRITE;
            if (ap) begin
                ad_p <= HADDR[7:0];
                exp_sd <= sd;
            end
            if (wr_p && HREADY && ad_p[7:2] == 6'h00) cst <= HWDATA[15:0];
            if (wr_p && HREADY && ad_p[7:2] == 6'h01) sd <= HWDATA[15:0];
            if (wr_p && HREADY && ad_p[7:2] == 6'h04) pwd <= HWDATA[3:0];
            hi_cnt <= TRIG_OUT[0] ? hi_cnt + 5'h01 : 5'h00;
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    property p_upper_zero;
        rd_p |-> HRDATA[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read data bits not zero");
    property p_unimpl_zero;
        rd_p && ad_p[7:2] == 6'h00 |-> (HRDATA[15:0] & 16'h483C) == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented status bits read nonzero");
    property p_limit_readback;
        rd_p && ad_p[7:2] == 6'h01 && !cst[8] |-> HRDATA[15:0] == exp_sd;
    endproperty
    a_limit_readback: assert property (p_limit_readback)
        else $error("step delay limit read differs from written value");
    property p_disabled_zero;
        !cst[15] [*3] |-> TRIG_OUT == 4'h0;
    endproperty
    a_disabled_zero: assert property (p_disabled_zero)
        else $error("trigger output active while disabled");
    property p_disabled_stable;
        !cst[15] [*3] |=> $stable(TRIG_OUT);
    endproperty
    a_disabled_stable: assert property (p_disabled_stable)
        else $error("trigger output moved while disabled");
    property p_stop_quiet;
        (cst[15] && !cst[7] && cst[12]) [*4] |=> $stable(TRIG_OUT);
    endproperty
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("trigger output moved after stop");
    property p_idle_freeze;
        (cst[15] && cst[13] && cst[12] && IDLE_MODE) [*5] |=> $stable(TRIG_OUT);
    endproperty
    a_idle_freeze: assert property (p_idle_freeze)
        else $error("trigger output moved while stopped in idle");
    property p_toggle_one;
        cst[15] && cst[12] && $past(cst[15]) && $past(cst[15], 2)
            && TRIG_OUT != $past(TRIG_OUT)
            |-> $onehot(TRIG_OUT ^ $past(TRIG_OUT));
    endproperty
    a_toggle_one: assert property (p_toggle_one)
        else $error("toggle changed more than one output");
    property p_pulse_width;
        $fell(TRIG_OUT[0]) && cst[15] && !cst[12] && $past(cst[15])
            |-> hi_cnt == {1'b0, pwd} + 5'h01;
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("trigger pulse width wrong");
    c_pulse: cover property ($fell(TRIG_OUT[0]) && !cst[12]);
    c_wdt: cover property (rd_p && ad_p == 8'h00 && HRDATA[6]);
    c_vis: cover property (rd_p && ad_p[7:2] == 6'h01 && cst[8]);
endmodule // tsc_assertions

bind tsc_top tsc_assertions u_chk (.REF_CLK, .RESET_N, .HSEL, .HADDR,
    .HTRANS, .HWRITE, .HWDATA, .HREADY, .HRDATA, .IDLE_MODE, .TRIG_OUT);

// file: test/tb.sv
// testbench: register table rows, then sequencer and watchdog cases
`timescale 1ns/10ps
module tb;
    import tsc_pkg::*;
    localparam int PW = 2;
    localparam logic [7:0] RA [8] = '{8'h00, 8'h00, 8'h00, 8'h04,
        8'h08, 8'h0C, 8'h10, 8'h20};
    localparam logic [31:0] RW [8] = '{32'hFFFF3300, 32'h0000CC3C,
        32'h00008003, 32'h1234, 32'hABCD, 32'h0F0F, 32'h35, 32'hFFFF};
    localparam logic [31:0] RE [8] = '{32'h3300, 32'h8400, 32'h8403,
        32'h1234, 32'hABCD, 32'h0F0F, 32'h5, 32'h0};
    logic REF_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HWDATA = 32'h0;
    logic HREADY;
    logic [31:0] HRDATA;
    logic HREADYOUT;
    logic HRESP;
    logic IDLE_MODE = 1'b0;
    logic [NUM_IN-1:0] TRIG_IN = 4'h0;
    logic [NUM_OUT-1:0] TRIG_OUT;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    int tg;
    int hi;
    // single slave: its ready out is the bus ready
    assign HREADY = HREADYOUT;
    tsc_top DUT (.REF_CLK, .RESET_N, .HSEL, .HADDR, .HTRANS, .HWRITE,
        .HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP,
        .IDLE_MODE, .TRIG_IN, .TRIG_OUT);
    initial begin
        forever #25 REF_CLK = ~REF_CLK;
    end
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end
    task summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task check_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task check_cnt(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task bus_wait();
        @(posedge REF_CLK);
        while (HREADY !== 1'b1) @(posedge REF_CLK);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HADDR <= {24'h0, a};
        HWRITE <= 1'b1;
        HTRANS <= 2'h2;
        bus_wait();
        HTRANS <= 2'h0;
        HWDATA <= d;
        bus_wait();
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] e,
               input logic [31:0] m);
        HSEL <= 1'b1;
        HADDR <= {24'h0, a};
        HWRITE <= 1'b0;
        HTRANS <= 2'h2;
        bus_wait();
        HTRANS <= 2'h0;
        bus_wait();
        check_reg(HRDATA & m, e);
    endtask
    // counts changes and high cycles of output 0 over n cycles
    task run(input int n);
        logic prev;
        tg = 0;
        hi = 0;
        prev = TRIG_OUT[0];
        repeat (n) begin
            @(posedge REF_CLK);
            if (TRIG_OUT[0] !== prev) tg++;
            if (TRIG_OUT[0] === 1'b1) hi++;
            prev = TRIG_OUT[0];
        end
    endtask
    task done(input string s);
        $display("test %s done", s);
    endtask
    initial begin
        repeat (10) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        rdchk(OFF_CST, 32'h0, 32'hFFFFFFFF);
        rdchk(OFF_PWD, 32'h0, 32'hFFFFFFFF);
        done("reset values");
        for (int i = 0; i < 8; i++) begin
            wr(RA[i], RW[i]);
            rdchk(RA[i], RE[i], 32'hFFFFFFFF);
        end
        done("register rows");
        wr(OFF_CST, 32'h8100);
        rdchk(OFF_SDLIM, 32'h0, 32'hFFFFFFFF);
        rdchk(OFF_CST, 32'h8500, 32'hFFFFFFFF);
        wr(OFF_CST, 32'h0);
        wr(OFF_SDLIM, 32'h0);
        wr(OFF_PWD, PW);
        for (int i = 0; i < PROG_DEPTH; i++) wr(OFF_PROG + 8'(i * 4), 32'h10);
        done("visibility");
        wr(OFF_CST, 32'h8280);
        run(40);
        check_cnt(hi, PW + 1);
        rdchk(OFF_CST, 32'h8200, 32'hFFFFFBFF);
        wr(OFF_CST, 32'h9280);
        run(40);
        check_cnt(tg, 1);
        check_reg({31'h0, TRIG_OUT[0]}, 32'h1);
        done("single step");
        wr(OFF_CST, 32'h9080);
        run(60);
        check_cnt(tg >= 5, 1);
        wr(OFF_CST, 32'h9000);
        run(50);
        check_cnt(tg, 0);
        wr(OFF_CST, 32'h1000);
        run(5);
        check_reg({28'h0, TRIG_OUT}, 32'h0);
        wr(OFF_CST, 32'h1080);
        run(50);
        check_cnt(tg, 0);
        done("start and enable");
        IDLE_MODE <= 1'b1;
        wr(OFF_CST, 32'hB080);
        run(50);
        check_cnt(tg, 0);
        IDLE_MODE <= 1'b0;
        run(50);
        check_cnt(tg > 0, 1);
        done("stop in idle");
        wr(OFF_CST, 32'h0);
        wr(OFF_PROG, 32'h40);
        wr(OFF_CST, 32'h9480);
        run(60);
        check_cnt(tg > 0, 1);
        rdchk(OFF_CST, 32'h9080, 32'hFFFFFFFF);
        wr(OFF_CST, 32'h0);
        wr(OFF_CST, 32'h9080);
        run(60);
        check_cnt(tg, 0);
        run(WDT_CYCLES);
        rdchk(OFF_CST, 32'h9040, 32'hFFFFFFFF);
        wr(OFF_CST, 32'h9040);
        rdchk(OFF_CST, 32'h9040, 32'hFFFFFFFF);
        wr(OFF_CST, 32'h9000);
        rdchk(OFF_CST, 32'h9000, 32'hFFFFFFFF);
        done("software trigger and watchdog");
        wr(OFF_CST, 32'h0);
        wr(OFF_PROG, 32'h20);
        wr(OFF_CST, 32'h9083);
        run(30);
        check_cnt(tg, 0);
        TRIG_IN <= 4'h1;
        run(40);
        check_cnt(tg > 0, 1);
        TRIG_IN <= 4'h0;
        done("input wait");
        RESET_N <= 1'b0;
        run(10);
        check_reg({28'h0, TRIG_OUT}, 32'h0);
        RESET_N <= 1'b1;
        run(3);
        rdchk(OFF_CST, 32'h0, 32'hFFFFFFFF);
        done("second reset");
        summarize();
    end
endmodule // tb
